// ===== cpl_cfg.svh
// console panel constants: register offsets, field positions, reset values
`ifndef CPL_CFG_SVH
`define CPL_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CPL_OFF_DATA_LO 8'h00
`define CPL_OFF_DATA_HI 8'h04
`define CPL_OFF_ADDR 8'h08
`define CPL_OFF_SWITCH 8'h0C
`define CPL_OFF_MI_LO 8'h10
`define CPL_OFF_MI_HI 8'h14
`define CPL_OFF_PI_LAMPS 8'h18
`define CPL_OFF_PI_COND 8'h1C
`define CPL_OFF_STATUS 8'h20

// ****************************************
// field positions
// ****************************************
`define CPL_SW_SENSE 0
`define CPL_SW_PAGE 8
`define CPL_SW_STOPSEL 12
`define CPL_SW_MIDIS 16
`define CPL_PIC_GEN 8
`define CPL_PIC_ON 28
`define CPL_PIL_REQ 8
`define CPL_PIL_ACC 16
`define CPL_PIL_HELD 24
`define CPL_ST_RUN 0
`define CPL_ST_MAN 1
`define CPL_ST_PROG 2
`define CPL_ST_MEMSTOP 3
`define CPL_ST_PF 4
`define CPL_ST_IDLE 5
`define CPL_ST_MODE 8

// ****************************************
// synchronised pin vector layout
// ****************************************
`define CPL_B_DATA 0
`define CPL_B_ADDR 36
`define CPL_B_SENSE 58
`define CPL_B_CTL 64
`define CPL_B_LOCKD 70
`define CPL_B_LOCKC 71
`define CPL_B_FAULT 72
`define CPL_PIN_W 75
`define CPL_K_DCLR 0
`define CPL_K_DLD 1
`define CPL_K_ACLR 2
`define CPL_K_ALD 3
`define CPL_K_STOP 4
`define CPL_K_RESET 5

// ****************************************
// encodings and reset values
// ****************************************
`define CPL_STOP_INSTR 2'h0
`define CPL_STOP_MEMREF 2'h1
`define CPL_STOP_CLOCK 2'h2
`define CPL_PAGE_EXEC 0
`define CPL_PAGE_USER 1
`define CPL_IO_OPC 3'h7
`define CPL_MODE_KERNEL 4'h1
`define CPL_MODE_SUPER 4'h2
`define CPL_MODE_CONCEAL 4'h4
`define CPL_MODE_PUBLIC 4'h8
`define CPL_RST_PAGE 2'h3

`endif

// ===== cpl_console.sv
// console panel logic: switches, indicators, interrupt lamps, stop control
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "cpl_cfg.svh"
module cpl_console (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// operator pins, asynchronous
	input wire logic [35:0] i_data_buttons,
	input wire logic [21:0] i_addr_buttons,
	input wire logic [5:0] i_sense_buttons,
	input wire logic [5:0] i_key_buttons,
	input wire logic i_lock_data,
	input wire logic i_lock_console,
	input wire logic [2:0] i_fault,
	// processor core
	input wire logic i_start,
	input wire logic i_instr_done,
	input wire logic i_halt_done,
	input wire logic [17:0] i_halt_jump,
	input wire logic [17:0] i_halt_pc,
	input wire logic [17:0] i_ir,
	input wire logic i_mb_ind,
	input wire logic [3:0] i_mb_index,
	input wire logic i_mem_ref,
	input wire logic [21:0] i_mem_addr,
	input wire logic [35:0] i_mem_data,
	input wire logic i_key_mem_ref,
	input wire logic i_user_flag,
	input wire logic i_public_flag,
	input wire logic i_compare_enable,
	input wire logic [6:0] i_bus_request,
	input wire logic [6:0] i_pi_grant,
	input wire logic [6:0] i_pi_dismiss,
	// switch registers
	output logic [35:0] o_data_switches,
	output logic [21:0] o_addr_switches,
	output logic [5:0] o_sense_switches,
	// indicators
	output logic [35:0] o_memory_indicator_row,
	output logic o_program_data_marker,
	output logic o_memory_data_marker,
	output logic o_io_instruction,
	output logic [6:0] o_io_device_code,
	output logic [2:0] o_io_function,
	output logic o_indirect_lamp,
	output logic [3:0] o_index_lamps,
	output logic [3:0] o_mode_lamps,
	// interrupt lamps
	output logic [6:0] o_channel_enabled_lamps,
	output logic [6:0] o_bus_request_lamps,
	output logic [6:0] o_accepted_request_lamps,
	output logic [6:0] o_held_interrupt_lamps,
	output logic [6:0] o_program_generated_request,
	output logic [2:0] o_serviced_channel,
	output logic o_serviced_valid,
	output logic o_interrupt_system_on,
	output logic o_interrupts_idle,
	// run and stop
	output logic o_run,
	output logic o_memory_stop,
	output logic o_manual_stop_indicator,
	output logic o_program_stop_indicator,
	output logic [17:0] o_address_display,
	output logic [17:0] o_arithmetic_register,
	output logic o_power_failure,
	output logic o_power_shutdown
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [2:0] lowest(input logic [6:0] v);
		lowest = 3'h0;
		for (int i = 6; i >= 0; i--) begin
			if (v[i]) begin
				lowest = i[2:0];
			end
		end
	endfunction

	function automatic logic addr_hit(input logic [21:0] a, input logic [21:0] sw,
			input logic [1:0] pg, input logic user, input logic cmp_en);
		logic space_ok;
		space_ok = user ? (pg[`CPL_PAGE_USER] & cmp_en) : pg[`CPL_PAGE_EXEC];
		addr_hit = space_ok && (a == sw);
	endfunction

	// ****************************************
	// state
	// ****************************************
	cpl_pkg::cpl_state_t st;
	cpl_pkg::cpl_state_t next_st;
	logic [`CPL_PIN_W-1:0] raw_pins;
	logic [`CPL_PIN_W-1:0] rise;
	logic [`CPL_PIN_W-1:0] next_pins;
	logic [5:0] keys;
	logic lock_d;
	logic lock_c;
	logic setup;
	logic wr;
	logic hit;
	logic [6:0] new_acc;

	assign raw_pins = {i_fault, i_lock_console, i_lock_data, i_key_buttons, i_sense_buttons,
		i_addr_buttons, i_data_buttons};

	always_comb begin
		next_st = st;
		// three-stage sync; a change counts only once stages two and three agree
		next_st.s1 = raw_pins;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_pins = (st.s2 & st.s3) | (st.pins & (st.s2 | st.s3));
		next_st.pins = next_pins;
		rise = next_pins & ~st.pins;
		lock_d = st.pins[`CPL_B_LOCKD];
		lock_c = st.pins[`CPL_B_LOCKC];
		// console lock blocks the control keys; the sense buttons still toggle unless data lock is on
		keys = lock_c ? 6'h00 : rise[`CPL_B_CTL +: 6];
		setup = i_psel && !i_penable;
		wr = i_psel && i_penable && st.pready && i_pwrite;
		hit = i_mem_ref && addr_hit(i_mem_addr, st.addr_sw, st.page_sw, i_user_flag,
			i_compare_enable);

		// ****************************************
		// switch registers
		// ****************************************
		if (!lock_d && !lock_c) begin
			next_st.data_sw = st.data_sw ^ rise[`CPL_B_DATA +: 36];
			if (keys[`CPL_K_DCLR]) begin
				next_st.data_sw = 36'h0;
			end else if (keys[`CPL_K_DLD]) begin
				next_st.data_sw = st.mi;
			end
		end
		if (!lock_d) begin
			next_st.sense_sw = st.sense_sw ^ rise[`CPL_B_SENSE +: 6];
		end
		if (!lock_c) begin
			next_st.addr_sw = st.addr_sw ^ rise[`CPL_B_ADDR +: 22];
		end
		if (keys[`CPL_K_ACLR]) begin
			next_st.addr_sw = 22'h0;
		end else if (keys[`CPL_K_ALD]) begin
			next_st.addr_sw = st.mi[21:0];
		end

		// ****************************************
		// instruction display and lamps
		// ****************************************
		next_st.io_instr = i_ir[17:15] == `CPL_IO_OPC;
		next_st.io_dev = i_ir[14:8];
		next_st.io_fn = i_ir[7:5];
		next_st.ind_lamp = i_mb_ind;
		next_st.index_lamps = i_mb_index;
		unique case ({i_user_flag, i_public_flag})
			2'h0: next_st.mode = `CPL_MODE_KERNEL;
			2'h1: next_st.mode = `CPL_MODE_SUPER;
			2'h2: next_st.mode = `CPL_MODE_CONCEAL;
			2'h3: next_st.mode = `CPL_MODE_PUBLIC;
		endcase

		// ****************************************
		// memory indicators
		// ****************************************
		if (st.run && hit && !st.mi_lock) begin
			next_st.mi = i_mem_data;
			next_st.prog_mark = 1'b0;
		end
		// releases first so a program write in the same cycle relocks
		if (st.mi_dis || i_key_mem_ref || keys[`CPL_K_RESET]) begin
			next_st.mi_lock = 1'b0;
		end
		if (keys[`CPL_K_RESET]) begin
			next_st.prog_mark = 1'b0;
		end

		// ****************************************
		// interrupt channels
		// ****************************************
		next_st.bus_req = i_bus_request;
		new_acc = ((i_bus_request & st.pi_en) | st.program_generated_request) & ~st.held;
		next_st.held = (st.held & ~i_pi_dismiss) | i_pi_grant;
		next_st.acc = (st.acc | new_acc) & ~next_st.held;
		next_st.svc = lowest(next_st.held);
		next_st.svc_valid = next_st.held != 7'h0;
		next_st.idle = (next_st.held == 7'h0) && (next_st.acc == 7'h0);

		// ****************************************
		// power fault
		// ****************************************
		if (st.pins[`CPL_B_FAULT +: 3] != 3'h0) begin
			next_st.shutdown = 1'b1;
		end

		// ****************************************
		// run and stop
		// ****************************************
		if (keys[`CPL_K_STOP]) begin
			next_st.stop_pend = 1'b1;
		end
		if (i_start) begin
			next_st.run = 1'b1;
			next_st.man_stop = 1'b0;
			next_st.prog_stop = 1'b0;
			next_st.mem_stop = 1'b0;
		end
		if (st.stop_pend && st.run) begin
			unique case (st.stop_sel)
				`CPL_STOP_INSTR: begin
					if (i_instr_done) begin
						next_st.run = 1'b0;
						next_st.man_stop = 1'b1;
						next_st.stop_pend = 1'b0;
					end
				end
				`CPL_STOP_MEMREF: begin
					// run stays lit while paused in a reference
					if (hit) begin
						next_st.mem_stop = 1'b1;
						next_st.man_stop = 1'b1;
						next_st.stop_pend = 1'b0;
					end
				end
				default: begin
					next_st.run = 1'b0;
					next_st.man_stop = 1'b1;
					next_st.stop_pend = 1'b0;
				end
			endcase
		end
		if (i_halt_done) begin
			next_st.run = 1'b0;
			next_st.prog_stop = 1'b1;
			next_st.addr_disp = i_halt_jump;
			next_st.arith = i_halt_pc + 18'h1;
		end
		if (keys[`CPL_K_RESET]) begin
			// reset key stops the processor whatever it is doing
			next_st.run = 1'b0;
			next_st.man_stop = 1'b1;
			next_st.mem_stop = 1'b0;
			next_st.stop_pend = 1'b0;
		end

		// ****************************************
		// apb slave, zero wait: pready in first access cycle
		// ****************************************
		next_st.pready = setup;
		next_st.pslverr = 1'b0;
		next_st.prdata = 32'h0;
		if (setup) begin
			unique case (i_paddr)
				`CPL_OFF_DATA_LO: next_st.prdata = st.data_sw[31:0];
				`CPL_OFF_DATA_HI: next_st.prdata = {28'h0, st.data_sw[35:32]};
				`CPL_OFF_ADDR: next_st.prdata = {10'h0, st.addr_sw};
				`CPL_OFF_SWITCH: begin
					next_st.prdata[`CPL_SW_SENSE +: 6] = st.sense_sw;
					next_st.prdata[`CPL_SW_PAGE +: 2] = st.page_sw;
					next_st.prdata[`CPL_SW_STOPSEL +: 2] = st.stop_sel;
					next_st.prdata[`CPL_SW_MIDIS] = st.mi_dis;
				end
				`CPL_OFF_MI_LO: next_st.prdata = st.mi[31:0];
				`CPL_OFF_MI_HI: next_st.prdata = {28'h0, st.mi[35:32]};
				`CPL_OFF_PI_LAMPS: begin
					next_st.prdata[6:0] = st.pi_en;
					next_st.prdata[`CPL_PIL_REQ +: 7] = st.bus_req;
					next_st.prdata[`CPL_PIL_ACC +: 7] = st.acc;
					next_st.prdata[`CPL_PIL_HELD +: 7] = st.held;
				end
				`CPL_OFF_PI_COND: begin
					next_st.prdata[6:0] = st.pi_en;
					next_st.prdata[`CPL_PIC_GEN +: 7] = st.program_generated_request;
					next_st.prdata[`CPL_PIC_ON] = st.interrupt_system_on;
				end
				`CPL_OFF_STATUS: begin
					next_st.prdata[`CPL_ST_RUN] = st.run;
					next_st.prdata[`CPL_ST_MAN] = st.man_stop;
					next_st.prdata[`CPL_ST_PROG] = st.prog_stop;
					next_st.prdata[`CPL_ST_MEMSTOP] = st.mem_stop;
					next_st.prdata[`CPL_ST_PF] = st.power_fail;
					next_st.prdata[`CPL_ST_IDLE] = st.idle;
					next_st.prdata[`CPL_ST_MODE +: 4] = st.mode;
				end
				default: next_st.pslverr = 1'b1;
			endcase
		end
		if (wr) begin
			unique case (i_paddr)
				`CPL_OFF_DATA_LO: next_st.data_sw[31:0] = i_pwdata;
				`CPL_OFF_DATA_HI: next_st.data_sw[35:32] = i_pwdata[3:0];
				`CPL_OFF_ADDR: next_st.addr_sw = i_pwdata[21:0];
				`CPL_OFF_SWITCH: begin
					next_st.sense_sw = i_pwdata[`CPL_SW_SENSE +: 6];
					next_st.page_sw = i_pwdata[`CPL_SW_PAGE +: 2];
					next_st.stop_sel = i_pwdata[`CPL_SW_STOPSEL +: 2];
					next_st.mi_dis = i_pwdata[`CPL_SW_MIDIS];
				end
				`CPL_OFF_MI_LO, `CPL_OFF_MI_HI: begin
					if (i_paddr == `CPL_OFF_MI_LO) begin
						next_st.mi[31:0] = i_pwdata;
					end else begin
						next_st.mi[35:32] = i_pwdata[3:0];
					end
					next_st.mi_lock = 1'b1;
					next_st.prog_mark = 1'b1;
				end
				`CPL_OFF_PI_COND: begin
					next_st.pi_en = i_pwdata[6:0];
					next_st.program_generated_request = i_pwdata[`CPL_PIC_GEN +: 7];
					next_st.interrupt_system_on = i_pwdata[`CPL_PIC_ON];
				end
				default: begin
				end
			endcase
		end
		// write one clears power failure; a fault in the same cycle wins
		next_st.power_fail = (st.power_fail && !(wr && i_paddr == `CPL_OFF_STATUS
			&& i_pwdata[`CPL_ST_PF])) || next_st.shutdown && st.pins[`CPL_B_FAULT +: 3] != 3'h0;
		next_st.shutdown = st.shutdown || st.pins[`CPL_B_FAULT +: 3] != 3'h0;
		next_st.mem_mark = !next_st.prog_mark;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st <= '0;
			st.page_sw <= `CPL_RST_PAGE;
			st.mode <= `CPL_MODE_KERNEL;
			st.mem_mark <= 1'b1;
			st.idle <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_prdata = st.prdata;
	assign o_pready = st.pready;
	assign o_pslverr = st.pslverr;
	assign o_data_switches = st.data_sw;
	assign o_addr_switches = st.addr_sw;
	assign o_sense_switches = st.sense_sw;
	assign o_memory_indicator_row = st.mi;
	assign o_program_data_marker = st.prog_mark;
	assign o_memory_data_marker = st.mem_mark;
	assign o_io_instruction = st.io_instr;
	assign o_io_device_code = st.io_dev;
	assign o_io_function = st.io_fn;
	assign o_indirect_lamp = st.ind_lamp;
	assign o_index_lamps = st.index_lamps;
	assign o_mode_lamps = st.mode;
	assign o_channel_enabled_lamps = st.pi_en;
	assign o_bus_request_lamps = st.bus_req;
	assign o_accepted_request_lamps = st.acc;
	assign o_held_interrupt_lamps = st.held;
	assign o_program_generated_request = st.program_generated_request;
	assign o_serviced_channel = st.svc;
	assign o_serviced_valid = st.svc_valid;
	assign o_interrupt_system_on = st.interrupt_system_on;
	assign o_interrupts_idle = st.idle;
	assign o_run = st.run;
	assign o_memory_stop = st.mem_stop;
	assign o_manual_stop_indicator = st.man_stop;
	assign o_program_stop_indicator = st.prog_stop;
	assign o_address_display = st.addr_disp;
	assign o_arithmetic_register = st.arith;
	assign o_power_failure = st.power_fail;
	assign o_power_shutdown = st.shutdown;

	// ****************************************
	// assertions
	// ****************************************
	property p_halt_stop;
		@(posedge i_clock) disable iff (i_rst)
		i_halt_done && !keys[`CPL_K_RESET] |=> o_program_stop_indicator && !o_run;
	endproperty
	a_halt_stop: assert property (p_halt_stop) else $error("halt did not stop");

	property p_halt_arith;
		@(posedge i_clock) disable iff (i_rst)
		i_halt_done |=> o_arithmetic_register == $past(i_halt_pc) + 18'h1
			&& o_address_display == $past(i_halt_jump);
	endproperty
	a_halt_arith: assert property (p_halt_arith) else $error("halt displays wrong");

	property p_mode_onehot;
		@(posedge i_clock) disable iff (i_rst)
		$onehot(o_mode_lamps);
	endproperty
	a_mode_onehot: assert property (p_mode_onehot) else $error("mode lamps not one-hot");

	property p_fault_power;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault != 3'h0) [*4] |=> ##[0:1] o_power_failure && o_power_shutdown;
	endproperty
	a_fault_power: assert property (p_fault_power) else $error("fault did not shut down");

	property p_held_excl;
		@(posedge i_clock) disable iff (i_rst)
		(o_held_interrupt_lamps & o_accepted_request_lamps) == 7'h0;
	endproperty
	a_held_excl: assert property (p_held_excl) else $error("held and accepted overlap");

	property p_accept_enabled;
		@(posedge i_clock) disable iff (i_rst)
		##1 (o_accepted_request_lamps & ~$past(o_accepted_request_lamps)
			& ~($past(o_channel_enabled_lamps) | $past(o_program_generated_request))) == 7'h0;
	endproperty
	a_accept_enabled: assert property (p_accept_enabled) else $error("disabled accept");

	property p_idle;
		@(posedge i_clock) disable iff (i_rst)
		o_interrupts_idle == (o_held_interrupt_lamps == 7'h0 && o_accepted_request_lamps == 7'h0);
	endproperty
	a_idle: assert property (p_idle) else $error("idle signal wrong");

	property p_reset_key;
		@(posedge i_clock) disable iff (i_rst)
		keys[`CPL_K_RESET] |=> !o_run && o_manual_stop_indicator;
	endproperty
	a_reset_key: assert property (p_reset_key) else $error("reset key did not stop");

	property p_service;
		@(posedge i_clock) disable iff (i_rst)
		o_serviced_valid |-> o_held_interrupt_lamps[o_serviced_channel]
			&& (o_held_interrupt_lamps & ((7'h1 << o_serviced_channel) - 7'h1)) == 7'h0;
	endproperty
	a_service: assert property (p_service) else $error("serviced channel not lowest");
endmodule

// ===== cpl_panel_model.sv
// operator pushbutton model for the console panel
`timescale 1ns/1ps
module cpl_panel_model (
	// clock
	input wire logic i_clock,
	// button pins
	output logic [35:0] o_data_buttons,
	output logic [5:0] o_key_buttons
);
	// ****************************************
	// press and release
	// ****************************************
	initial begin
		o_data_buttons = 36'h0;
		o_key_buttons = 6'h0;
	end
	// held past the filters, then back to released so no stale level lingers
	task automatic press(input logic key, input int idx);
		@(posedge i_clock);
		if (key) o_key_buttons[idx] <= 1'b1;
		else o_data_buttons[idx] <= 1'b1;
		repeat (5) @(posedge i_clock);
		o_key_buttons <= 6'h0;
		o_data_buttons <= 36'h0;
		repeat (6) @(posedge i_clock);
	endtask
endmodule

// ===== cpl_pkg.sv
// console panel state type
`include "cpl_cfg.svh"
package cpl_pkg;
	typedef struct packed {
		logic [`CPL_PIN_W-1:0] s1;
		logic [`CPL_PIN_W-1:0] s2;
		logic [`CPL_PIN_W-1:0] s3;
		logic [`CPL_PIN_W-1:0] pins;
		logic [35:0] data_sw;
		logic [21:0] addr_sw;
		logic [5:0] sense_sw;
		logic [1:0] page_sw;
		logic [1:0] stop_sel;
		logic mi_dis;
		logic [35:0] mi;
		logic mi_lock;
		logic prog_mark;
		logic mem_mark;
		logic [6:0] pi_en;
		logic [6:0] program_generated_request;
		logic [6:0] bus_req;
		logic [6:0] acc;
		logic [6:0] held;
		logic [2:0] svc;
		logic svc_valid;
		logic interrupt_system_on;
		logic idle;
		logic [3:0] mode;
		logic run;
		logic man_stop;
		logic prog_stop;
		logic mem_stop;
		logic stop_pend;
		logic power_fail;
		logic shutdown;
		logic [17:0] addr_disp;
		logic [17:0] arith;
		logic io_instr;
		logic [6:0] io_dev;
		logic [2:0] io_fn;
		logic ind_lamp;
		logic [3:0] index_lamps;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} cpl_state_t;
endpackage

// ===== tb.sv
// self-checking testbench for the console panel
`timescale 1ns/1ps
`include "cpl_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	logic i_clock = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, exp_q[$];
	logic [35:0] o_data_switches, o_memory_indicator_row, db, i_mem_data = 36'h0;
	logic [21:0] o_addr_switches, i_addr_buttons = 22'h0, i_mem_addr = 22'h0;
	logic [17:0] o_address_display, o_arithmetic_register, i_ir = 18'h0;
	logic [17:0] i_halt_jump = 18'h0, i_halt_pc = 18'h0;
	logic [6:0] o_io_device_code, o_channel_enabled_lamps, o_bus_request_lamps;
	logic [6:0] o_accepted_request_lamps, o_held_interrupt_lamps, o_program_generated_request;
	logic [6:0] i_bus_request = 7'h0, i_pi_grant = 7'h0, i_pi_dismiss = 7'h0;
	logic [5:0] o_sense_switches, kb, i_sense_buttons = 6'h00;
	logic [3:0] o_index_lamps, o_mode_lamps, i_mb_index = 4'h0;
	logic [2:0] o_io_function, o_serviced_channel, i_fault = 3'h0;
	logic o_program_data_marker, o_memory_data_marker, o_io_instruction, o_indirect_lamp;
	logic o_serviced_valid, o_interrupt_system_on, o_interrupts_idle, o_run, o_memory_stop;
	logic o_manual_stop_indicator, o_program_stop_indicator, o_power_failure, o_power_shutdown;
	logic o_pready, o_pslverr, i_lock_data = 0, i_lock_console = 0, i_start = 0;
	logic i_instr_done = 0, i_key_mem_ref = 0, i_compare_enable = 0;
	logic i_halt_done = 0, i_mb_ind = 0, i_user_flag = 0, i_public_flag = 0, i_mem_ref = 0;
	int fail_count = 0, cmp_count = 0, seed;
	logic [31:0] d, exp_w;
	logic [21:0] ma;
	logic [35:0] mv;
	logic [17:0] j, p;
	// ****************************************
	// clock, instances, checker
	// ****************************************
	always #4 i_clock = ~i_clock;
	cpl_panel_model u_pm (.i_clock(i_clock), .o_data_buttons(db), .o_key_buttons(kb));
	cpl_console dut (.i_data_buttons(db), .i_key_buttons(kb), .*);
	// pop once: the compare macro names its expected value twice
	always @(posedge i_clock) if (o_pready === 1'b1 && i_pwrite === 1'b0) begin
		exp_w = exp_q.pop_front();
		`CHK(o_prdata, exp_w)
	end
	initial begin
		repeat (30000) @(posedge i_clock);
		fail_count++;
		close_out();
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic close_out();
		$display("counts: compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// a read hands its expected word in dv
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv, input logic e);
		int n;
		n = 0;
		if (!w) exp_q.push_back(dv);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= dv;
		@(posedge i_clock);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			fail_count++;
			close_out();
		end
		`CHK(o_pslverr, e)
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clock);
	endtask
	// lock levels need the synchronisers to settle
	task automatic lk(input logic dl, input logic cl);
		i_lock_data <= dl;
		i_lock_console <= cl;
		repeat (5) @(posedge i_clock);
	endtask
	// one memory reference pulse, then two edges for the indicators
	task automatic mref(input logic [21:0] ra, input logic [35:0] rv);
		i_mem_ref <= 1'b1;
		i_mem_addr <= ra;
		i_mem_data <= rv;
		@(posedge i_clock);
		i_mem_ref <= 1'b0;
		repeat (2) @(posedge i_clock);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		seed = 30506;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clock);
		`CHK(o_memory_data_marker, 1'b1)
		`CHK(o_interrupts_idle, 1'b1)
		$display("test reset done");
		d = $random(seed);
		apb(1, `CPL_OFF_DATA_LO, d, 0);
		apb(1, `CPL_OFF_DATA_HI, 32'h0000000A, 0);
		apb(1, `CPL_OFF_ADDR, d & 32'h003FFFFF, 0);
		apb(0, `CPL_OFF_DATA_LO, d, 0);
		apb(0, `CPL_OFF_DATA_HI, 32'h0000000A, 0);
		apb(0, 8'h40, 32'h0, 1);
		`CHK(o_addr_switches, d[21:0])
		u_pm.press(0, 3);
		`CHK(o_data_switches, {4'hA, d} ^ 36'h8)
		lk(1, 0);
		i_sense_buttons <= 6'h01;
		u_pm.press(0, 3);
		`CHK(o_data_switches, {4'hA, d} ^ 36'h8)
		`CHK(o_sense_switches, 6'h00)
		i_sense_buttons <= 6'h00;
		lk(0, 1);
		u_pm.press(1, 2);
		`CHK(o_addr_switches, d[21:0])
		lk(0, 0);
		u_pm.press(1, 2);
		i_sense_buttons <= 6'h01;
		u_pm.press(1, 0);
		i_sense_buttons <= 6'h00;
		`CHK(o_sense_switches, 6'h01)
		`CHK(o_addr_switches, 22'h0)
		`CHK(o_data_switches, 36'h0)
		$display("test switches done");
		for (int k = 0; k < 4; k++) begin
			{i_user_flag, i_public_flag} <= 2'(k);
			i_ir <= {3'h7, 15'($random(seed))};
			{i_mb_ind, i_mb_index} <= 5'($random(seed));
			repeat (2) @(posedge i_clock);
			`CHK(o_mode_lamps, 4'h1 << k)
			`CHK({o_io_instruction, o_io_device_code, o_io_function}, {1'b1, i_ir[14:5]})
			`CHK({o_indirect_lamp, o_index_lamps}, {i_mb_ind, i_mb_index})
		end
		i_fault <= 3'h4;
		repeat (6) @(posedge i_clock);
		`CHK({o_power_failure, o_power_shutdown}, 2'h3)
		i_fault <= 3'h0;
		$display("test lamps done");
		j = 18'($random(seed));
		p = 18'($random(seed));
		i_start <= 1'b1;
		@(posedge i_clock);
		i_start <= 1'b0;
		repeat (2) @(posedge i_clock);
		`CHK(o_run, 1'b1)
		{i_halt_done, i_halt_jump, i_halt_pc} <= {1'b1, j, p};
		@(posedge i_clock);
		i_halt_done <= 1'b0;
		repeat (2) @(posedge i_clock);
		`CHK({o_run, o_program_stop_indicator}, 2'h1)
		`CHK({o_address_display, o_arithmetic_register}, {j, 18'(p + 18'h1)})
		apb(1, `CPL_OFF_SWITCH, 32'h00002000, 0);
		i_start <= 1'b1;
		@(posedge i_clock);
		i_start <= 1'b0;
		u_pm.press(1, 4);
		`CHK({o_run, o_manual_stop_indicator}, 2'h1)
		$display("test stops done");
		apb(1, `CPL_OFF_PI_COND, 32'h10000005, 0);
		apb(0, `CPL_OFF_PI_COND, 32'h10000005, 0);
		i_bus_request <= 7'h06;
		repeat (3) @(posedge i_clock);
		`CHK(o_interrupt_system_on, 1'b1)
		`CHK({o_channel_enabled_lamps, o_bus_request_lamps}, {7'h05, 7'h06})
		`CHK(o_accepted_request_lamps, 7'h04)
		i_pi_grant <= 7'h04;
		@(posedge i_clock);
		i_pi_grant <= 7'h00;
		repeat (3) @(posedge i_clock);
		`CHK({o_held_interrupt_lamps, o_accepted_request_lamps}, {7'h04, 7'h00})
		`CHK({o_serviced_valid, o_serviced_channel, o_interrupts_idle}, 5'h14)
		i_pi_dismiss <= 7'h04;
		@(posedge i_clock);
		i_pi_dismiss <= 7'h00;
		repeat (3) @(posedge i_clock);
		`CHK({o_held_interrupt_lamps, o_accepted_request_lamps}, {7'h00, 7'h04})
		apb(1, `CPL_OFF_PI_COND, 32'h10004005, 0);
		@(posedge i_clock);
		`CHK({o_program_generated_request, o_accepted_request_lamps}, {7'h40, 7'h44})
		apb(0, `CPL_OFF_PI_LAMPS, 32'h00440605, 0);
		$display("test interrupts done");
		ma = 22'($random(seed));
		mv = {4'($random(seed)), $random(seed)};
		d = $random(seed);
		apb(1, `CPL_OFF_ADDR, 32'(ma), 0);
		apb(1, `CPL_OFF_SWITCH, 32'h00001100, 0);
		i_user_flag <= 1'b0;
		i_start <= 1'b1;
		@(posedge i_clock);
		i_start <= 1'b0;
		mref(ma, mv);
		`CHK(o_memory_indicator_row, mv)
		`CHK({o_program_data_marker, o_memory_data_marker}, 2'h1)
		apb(1, `CPL_OFF_MI_LO, d, 0);
		mref(ma, ~mv);
		apb(0, `CPL_OFF_MI_LO, d, 0);
		`CHK(o_memory_indicator_row, {mv[35:32], d})
		`CHK({o_program_data_marker, o_memory_data_marker}, 2'h2)
		i_key_mem_ref <= 1'b1;
		@(posedge i_clock);
		i_key_mem_ref <= 1'b0;
		mref(ma, ~mv);
		`CHK({o_memory_indicator_row, o_program_data_marker}, {~mv, 1'b0})
		u_pm.press(1, 4);
		`CHK({o_run, o_memory_stop}, 2'h2)
		mref(ma, mv);
		`CHK({o_run, o_memory_stop, o_manual_stop_indicator}, 3'h7)
		u_pm.press(1, 5);
		`CHK({o_run, o_memory_stop, o_manual_stop_indicator}, 3'h1)
		$display("test memory done");
		apb(1, `CPL_OFF_SWITCH, 32'h00000100, 0);
		i_start <= 1'b1;
		@(posedge i_clock);
		i_start <= 1'b0;
		u_pm.press(1, 4);
		`CHK({o_run, o_manual_stop_indicator}, 2'h2)
		i_instr_done <= 1'b1;
		@(posedge i_clock);
		i_instr_done <= 1'b0;
		repeat (2) @(posedge i_clock);
		`CHK({o_run, o_manual_stop_indicator}, 2'h1)
		apb(0, `CPL_OFF_STATUS, 32'h00000212, 0);
		apb(1, `CPL_OFF_STATUS, 32'h00000010, 0);
		`CHK(o_power_failure, 1'b0)
		$display("test stop modes done");
		close_out();
	end
endmodule
